// file: inc/tmopq_pkg.sv
// package for the one-pulse and encoder timer: register map, fields, resets
package tmopq_pkg;
    localparam int TMOPQ_AW = 4;
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_SLAVE_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_CHANNEL_MODE_ONE = 4'h2;
    localparam logic [3:0] ADDR_CHANNEL_ENABLE_POLARITY = 4'h3;
    localparam logic [3:0] ADDR_COUNTER_VALUE = 4'h4;
    localparam logic [3:0] ADDR_RELOAD_VALUE = 4'h5;
    localparam logic [3:0] ADDR_CH1_COMPARE_VALUE = 4'h6;
    localparam logic [3:0] ADDR_EVENT_GEN = 4'h7;
    // timer_control_one bit positions
    localparam int CR1_CEN_POS = 0;
    localparam int CR1_SSEL_POS = 3;
    localparam int CR1_DIR_POS = 4;
    localparam int CR1_ARBE_POS = 7;
    // slave_control fields
    localparam int SMC_SMS_LSB = 0;
    localparam int SMC_TS_LSB = 4;
    // channel_mode_one fields
    localparam int CM_CC1S_LSB = 0;
    localparam int CM_FE_POS = 2;
    localparam int CM_BE_POS = 3;
    localparam int CM_OCM_LSB = 4;
    localparam int CM_CC2S_LSB = 8;
    // channel_enable_polarity fields and the event generation update bit
    localparam int CE_CC1P_POS = 1;
    localparam int CE_CC2P_POS = 5;
    localparam int EG_UG_POS = 0;
    // field encodings and reset values
    localparam logic [2:0] SMS_ENC_B = 3'h1;
    localparam logic [2:0] SMS_ENC_A = 3'h2;
    localparam logic [2:0] SMS_ENC_AB = 3'h3;
    localparam logic [2:0] SMS_TRIGGER = 3'h6;
    localparam logic [2:0] TS_FILT_B = 3'h6;
    localparam logic [2:0] TS_FILT_A = 3'h5;
    localparam logic [1:0] MAP_DIRECT = 2'h1;
    localparam logic [2:0] OCM_FROZEN = 3'h0;
    localparam logic [2:0] OCM_SET = 3'h1;
    localparam logic [2:0] OCM_CLEAR = 3'h2;
    localparam logic [2:0] OCM_TOGGLE = 3'h3;
    localparam logic [2:0] OCM_FORCE_LO = 3'h4;
    localparam logic [2:0] OCM_FORCE_HI = 3'h5;
    localparam logic [2:0] OCM_PWM1 = 3'h6;
    localparam logic [2:0] OCM_PWM2 = 3'h7;
    localparam logic [15:0] RESET_RELOAD = 16'hffff;
    localparam logic [15:0] RESET_ZERO = 16'h0000;

    typedef struct packed {
        logic [2:0] sms;
        logic [2:0] ts;
        logic [1:0] cc1s;
        logic [1:0] cc2s;
        logic [2:0] ocm;
        logic fastEn;
        logic cc1p;
        logic cc2p;
    } tmopq_cfg_type;
endpackage : tmopq_pkg

// file: hdl/tmopq_timer.sv
// one-pulse and quadrature encoder timer channel pair
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - single shot stops counter at a wrap update, not on a forced update or in encoder modes
// - ch2 map 01 routes filtered b
// - ch2 polarity 0 means rising edge
// - trigger select 110 picks filtered b
// - slave mode 110 trigger starts counter
// - delay equals ch1 compare value
// - width equals reload minus compare
// - pwm2 rises at match, falls at reload
// - trigger edge sets count enable bit
// - fast enable forces match level on trigger
// - fast enable only in pwm modes
// - slave modes 001/010/011 pick encoder edges
// - polarity bits invert encoder inputs
// - count one per valid selected transition
// - direction recomputed on every input transition
// - encoder wraps between zero and reload
// - compare keeps working in encoder mode
// - a-only: rise down if b high
// - b-only: rise up if a high
// - both: each edge uses its own direction
module tmopq_timer
    import tmopq_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic encoderInA,
    input wire logic encoderInB,
    output logic compareReferenceOut,
    output logic ch1ComparePin
);
    logic rstSync1_q, rstSync2_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rst_n = rstSync2_q;

    // input synchronisers, then one more stage for edge detection
    logic aS1_q, aS2_q, aS3_q, bS1_q, bS2_q, bS3_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aS1_q <= 1'b0;
            aS2_q <= 1'b0;
            aS3_q <= 1'b0;
            bS1_q <= 1'b0;
            bS2_q <= 1'b0;
            bS3_q <= 1'b0;
        end else begin
            aS1_q <= encoderInA;
            aS2_q <= aS1_q;
            aS3_q <= aS2_q;
            bS1_q <= encoderInB;
            bS2_q <= bS1_q;
            bS3_q <= bS2_q;
        end
    end

    // registers
    logic countEnable_q, singleShotSelect_q, countDirection_q, reloadBufferEn_q;
    tmopq_cfg_type cfg_q;
    logic ch1CompareBufferEn_q;
    logic [CW-1:0] counter_q, reloadPre_q, reloadSh_q, cmpPre_q, cmpSh_q;
    logic ocRef_q;

    logic wrCr1, wrCnt, wrArr, wrCcr, forceUpdate;
    assign wrCr1 = regWr && (regAddr == ADDR_CONTROL_ONE);
    assign wrCnt = regWr && (regAddr == ADDR_COUNTER_VALUE);
    assign wrArr = regWr && (regAddr == ADDR_RELOAD_VALUE);
    assign wrCcr = regWr && (regAddr == ADDR_CH1_COMPARE_VALUE);
    assign forceUpdate = regWr && (regAddr == ADDR_EVENT_GEN) && regWdata[EG_UG_POS];

    // polarity-adjusted filtered inputs
    logic filtA, filtAPrev, filtB, filtBPrev;
    assign filtA = aS2_q ^ cfg_q.cc1p;
    assign filtAPrev = aS3_q ^ cfg_q.cc1p;
    assign filtB = bS2_q ^ cfg_q.cc2p;
    assign filtBPrev = bS3_q ^ cfg_q.cc2p;
    logic edgeA, edgeB, riseA, riseB;
    assign edgeA = filtA ^ filtAPrev;
    assign edgeB = filtB ^ filtBPrev;
    assign riseA = filtA & ~filtAPrev;
    assign riseB = filtB & ~filtBPrev;

    // trigger path
    logic chBMapped, chAMapped, slaveTriggerIn, trigMode;
    assign chBMapped = (cfg_q.cc2s == MAP_DIRECT);
    assign chAMapped = (cfg_q.cc1s == MAP_DIRECT);
    always_comb begin
        slaveTriggerIn = 1'b0;
        if (cfg_q.ts == TS_FILT_B) begin
            slaveTriggerIn = riseB && chBMapped;
        end else if (cfg_q.ts == TS_FILT_A) begin
            slaveTriggerIn = riseA && chAMapped;
        end
    end
    assign trigMode = (cfg_q.sms == SMS_TRIGGER);
    logic trigStart;
    assign trigStart = trigMode && slaveTriggerIn && !countEnable_q;

    // encoder decode
    logic encMode, encStep, encUp, dirA, dirB;
    assign encMode = (cfg_q.sms == SMS_ENC_B) || (cfg_q.sms == SMS_ENC_A)
        || (cfg_q.sms == SMS_ENC_AB);
    // up when a differs from b after an a edge, up when they match after a b edge
    assign dirA = filtA ^ filtB;
    assign dirB = ~(filtA ^ filtB);
    always_comb begin
        encStep = 1'b0;
        encUp = ~countDirection_q;
        if (edgeA) begin
            encUp = ~dirA ? 1'b0 : 1'b1;
        end else if (edgeB) begin
            encUp = dirB;
        end
        unique case (cfg_q.sms)
            SMS_ENC_A: encStep = edgeA;
            SMS_ENC_B: encStep = edgeB;
            SMS_ENC_AB: encStep = edgeA | edgeB;
            default: encStep = 1'b0;
        endcase
    end

    // counter tick and update
    logic tick, upCount, atTop, atBottom, updateEvt;
    assign upCount = encMode ? encUp : ~countDirection_q;
    assign tick = countEnable_q && (encMode ? encStep : 1'b1);
    assign atTop = (counter_q == reloadSh_q);
    assign atBottom = (counter_q == RESET_ZERO[CW-1:0]);
    assign updateEvt = forceUpdate || (tick && (upCount ? atTop : atBottom));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            counter_q <= RESET_ZERO[CW-1:0];
        end else if (wrCnt) begin
            counter_q <= regWdata[CW-1:0];
        end else if (forceUpdate) begin
            counter_q <= upCount ? RESET_ZERO[CW-1:0] : reloadSh_q;
        end else if (tick) begin
            if (upCount) begin
                counter_q <= atTop ? RESET_ZERO[CW-1:0] : counter_q + 1'b1;
            end else begin
                counter_q <= atBottom ? reloadSh_q : counter_q - 1'b1;
            end
        end
    end

    // control one: enable, single shot, direction, reload buffer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            countEnable_q <= 1'b0;
            singleShotSelect_q <= 1'b0;
            countDirection_q <= 1'b0;
            reloadBufferEn_q <= 1'b0;
        end else begin
            if (wrCr1) begin
                singleShotSelect_q <= regWdata[CR1_SSEL_POS];
                reloadBufferEn_q <= regWdata[CR1_ARBE_POS];
            end
            // hardware direction wins over software while encoding
            if (encMode && (edgeA || edgeB)) begin
                countDirection_q <= ~encUp;
            end else if (wrCr1) begin
                countDirection_q <= regWdata[CR1_DIR_POS];
            end
            // trigger start beats a same-cycle software clear
            if (trigStart) begin
                countEnable_q <= 1'b1;
            end else if (singleShotSelect_q && updateEvt && !forceUpdate && !encMode) begin
                countEnable_q <= 1'b0;
            end else if (wrCr1) begin
                countEnable_q <= regWdata[CR1_CEN_POS];
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
            ch1CompareBufferEn_q <= 1'b0;
        end else begin
            if (regWr && regAddr == ADDR_SLAVE_CONTROL) begin
                cfg_q.sms <= regWdata[SMC_SMS_LSB +: 3];
                cfg_q.ts <= regWdata[SMC_TS_LSB +: 3];
            end
            if (regWr && regAddr == ADDR_CHANNEL_MODE_ONE) begin
                cfg_q.cc1s <= regWdata[CM_CC1S_LSB +: 2];
                cfg_q.fastEn <= regWdata[CM_FE_POS];
                ch1CompareBufferEn_q <= regWdata[CM_BE_POS];
                cfg_q.ocm <= regWdata[CM_OCM_LSB +: 3];
                cfg_q.cc2s <= regWdata[CM_CC2S_LSB +: 2];
            end
            if (regWr && regAddr == ADDR_CHANNEL_ENABLE_POLARITY) begin
                cfg_q.cc1p <= regWdata[CE_CC1P_POS];
                cfg_q.cc2p <= regWdata[CE_CC2P_POS];
            end
        end
    end

    // preload and shadow registers for reload and compare
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reloadPre_q <= RESET_RELOAD[CW-1:0];
            reloadSh_q <= RESET_RELOAD[CW-1:0];
            cmpPre_q <= RESET_ZERO[CW-1:0];
            cmpSh_q <= RESET_ZERO[CW-1:0];
        end else begin
            if (wrArr) begin
                reloadPre_q <= regWdata[CW-1:0];
            end
            if (wrArr && !reloadBufferEn_q) begin
                reloadSh_q <= regWdata[CW-1:0];
            end else if (updateEvt) begin
                reloadSh_q <= reloadPre_q;
            end
            if (wrCcr) begin
                cmpPre_q <= regWdata[CW-1:0];
            end
            if (wrCcr && !ch1CompareBufferEn_q) begin
                cmpSh_q <= regWdata[CW-1:0];
            end else if (updateEvt) begin
                cmpSh_q <= cmpPre_q;
            end
        end
    end

    // compare output; runs in every counting mode
    logic cntBelow, pwmMode, matchNow, refNext, fastHold_q;
    assign cntBelow = counter_q < cmpSh_q;
    assign pwmMode = (cfg_q.ocm == OCM_PWM1) || (cfg_q.ocm == OCM_PWM2);
    assign matchNow = countEnable_q && (counter_q == cmpSh_q);
    always_comb begin
        refNext = ocRef_q;
        unique case (cfg_q.ocm)
            OCM_FROZEN: refNext = ocRef_q;
            OCM_SET: refNext = matchNow ? 1'b1 : ocRef_q;
            OCM_CLEAR: refNext = matchNow ? 1'b0 : ocRef_q;
            OCM_TOGGLE: refNext = matchNow ? ~ocRef_q : ocRef_q;
            OCM_FORCE_LO: refNext = 1'b0;
            OCM_FORCE_HI: refNext = 1'b1;
            OCM_PWM1: refNext = cntBelow;
            // high from compare match until the count reaches reload
            OCM_PWM2: refNext = ~cntBelow && !atTop;
        endcase
        // a fast start keeps the match level until the real compare catches up
        if (fastHold_q && pwmMode) begin
            refNext = (cfg_q.ocm == OCM_PWM2);
        end
        if (trigStart && cfg_q.fastEn && pwmMode) begin
            refNext = (cfg_q.ocm == OCM_PWM2);
        end
        if (pwmMode && singleShotSelect_q && !countEnable_q && !trigStart) begin
            refNext = (cfg_q.ocm == OCM_PWM1) ? cntBelow : 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ocRef_q <= 1'b0;
        end else begin
            ocRef_q <= refNext;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fastHold_q <= 1'b0;
        end else if (trigStart && cfg_q.fastEn && pwmMode) begin
            fastHold_q <= 1'b1;
        end else if (!countEnable_q || matchNow) begin
            fastHold_q <= 1'b0;
        end
    end
    assign compareReferenceOut = ocRef_q;
    assign ch1ComparePin = ocRef_q ^ cfg_q.cc1p;

    // read port, data one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            regRdata <= 32'h0000_0000;
            unique case (regAddr)
                ADDR_CONTROL_ONE: begin
                    regRdata[CR1_CEN_POS] <= countEnable_q;
                    regRdata[CR1_SSEL_POS] <= singleShotSelect_q;
                    regRdata[CR1_DIR_POS] <= countDirection_q;
                    regRdata[CR1_ARBE_POS] <= reloadBufferEn_q;
                end
                ADDR_SLAVE_CONTROL: begin
                    regRdata[SMC_SMS_LSB +: 3] <= cfg_q.sms;
                    regRdata[SMC_TS_LSB +: 3] <= cfg_q.ts;
                end
                ADDR_CHANNEL_MODE_ONE: begin
                    regRdata[CM_CC1S_LSB +: 2] <= cfg_q.cc1s;
                    regRdata[CM_FE_POS] <= cfg_q.fastEn;
                    regRdata[CM_BE_POS] <= ch1CompareBufferEn_q;
                    regRdata[CM_OCM_LSB +: 3] <= cfg_q.ocm;
                    regRdata[CM_CC2S_LSB +: 2] <= cfg_q.cc2s;
                end
                ADDR_CHANNEL_ENABLE_POLARITY: begin
                    regRdata[CE_CC1P_POS] <= cfg_q.cc1p;
                    regRdata[CE_CC2P_POS] <= cfg_q.cc2p;
                end
                ADDR_COUNTER_VALUE: regRdata[CW-1:0] <= counter_q;
                ADDR_RELOAD_VALUE: regRdata[CW-1:0] <= reloadPre_q;
                ADDR_CH1_COMPARE_VALUE: regRdata[CW-1:0] <= cmpPre_q;
                default: regRdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : tmopq_timer

// file: tb/tmopq_timer_properties.sv
// port assertions for the one-pulse and encoder timer
`timescale 1ns/10ps
module tmopq_timer_properties
    import tmopq_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic encoderInA,
    input wire logic encoderInB,
    input wire logic compareReferenceOut,
    input wire logic ch1ComparePin
);
    logic [31:0] regQ [0:7];
    logic [15:0] highQ;
    wire logic pwmTwo = regQ[2][CM_OCM_LSB +: 3] == OCM_PWM2;
    wire logic fastOn = regQ[2][CM_FE_POS];
    wire logic armB = regQ[1][SMC_SMS_LSB +: 3] == SMS_TRIGGER
        && regQ[1][SMC_TS_LSB +: 3] == TS_FILT_B
        && regQ[2][CM_CC2S_LSB +: 2] == MAP_DIRECT && !regQ[3][CE_CC2P_POS];
    // shadow of what software wrote
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regQ <= '{default: 32'h0};
        end else if (regWr && !regAddr[3]) begin
            regQ[regAddr[2:0]] <= regWdata;
        end
    end
    // cycles the reference output has been high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            highQ <= 16'h0;
        end else begin
            highQ <= compareReferenceOut ? highQ + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence trig_s;
        $rose(encoderInB) && armB;
    endsequence
    sequence shot_end_s;
        $fell(compareReferenceOut) && pwmTwo && !fastOn && regQ[0][CR1_SSEL_POS];
    endsequence
    unmapped_read_a: assert property (regRd && regAddr[3] |=> regRdata == 32'h0)
        else $error("unmapped read gave data");
    event_read_a: assert property (regRd && regAddr == ADDR_EVENT_GEN |=> regRdata == 32'h0)
        else $error("event register read gave data");
    pin_polarity_a: assert property (ch1ComparePin == (compareReferenceOut ^ regQ[3][CE_CC1P_POS]))
        else $error("compare pin polarity wrong");
    idle_after_reset_a: assert property ($rose(rstn) |-> !compareReferenceOut [*3])
        else $error("reference high after reset");
    fast_start_a: assert property (trig_s ##0 fastOn && pwmTwo
        |-> ##[3:6] compareReferenceOut) else $error("fast start too slow");
    fast_ignored_a: assert property (trig_s ##0 fastOn && !compareReferenceOut
        && regQ[2][CM_OCM_LSB +: 3] == OCM_SET |=> !compareReferenceOut [*6])
        else $error("fast enable acted outside pwm");
    shot_width_a: assert property (shot_end_s |-> highQ == regQ[5][15:0] - regQ[6][15:0])
        else $error("pulse width wrong");
    shot_stop_a: assert property (shot_end_s |-> !compareReferenceOut [*8])
        else $error("counter ran on after pulse");
endmodule : tmopq_timer_properties

// file: tb/tmopq_encoder_model.sv
// partner model: quadrature encoder and trigger source on the input pins
`timescale 1ns/10ps
module tmopq_encoder_model (
    input wire logic mclk,
    output logic encoderInA,
    output logic encoderInB
);
    logic [1:0] phase = 2'h0;
    initial begin
        encoderInA = 1'b0;
        encoderInB = 1'b0;
    end
    // one pin changes per step, so every step is unambiguous
    task automatic turn(input int steps, input logic back, input int gap);
        for (int i = 0; i < steps; i++) begin
            @(posedge mclk);
            phase = back ? phase - 2'h1 : phase + 2'h1;
            encoderInA <= phase[1] ^ phase[0];
            encoderInB <= phase[1];
            repeat (gap) @(posedge mclk);
        end
    endtask : turn
    task automatic drive(input logic level);
        @(posedge mclk);
        encoderInB <= level;
    endtask : drive
endmodule : tmopq_encoder_model

// file: tb/testbench.sv
// self-checking bench for the one-pulse and encoder timer
`timescale 1ns/10ps
module testbench
    import tmopq_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic encoderInA;
    logic encoderInB;
    logic compareReferenceOut;
    logic ch1ComparePin;
    int numErrors = 0;
    int nTests = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    tmopq_timer #(.CW(16)) tmopq_timer_i (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .encoderInA(encoderInA), .encoderInB(encoderInB),
        .compareReferenceOut(compareReferenceOut), .ch1ComparePin(ch1ComparePin));
    tmopq_encoder_model tmopq_encoder_model_i (.mclk(mclk), .encoderInA(encoderInA),
        .encoderInB(encoderInB));
    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : endOfTest
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic checkReg(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(exp, d);
    endtask : checkReg
    task automatic checkBit(input int pos, input logic exp);
        logic [31:0] d;
        rd(ADDR_CONTROL_ONE, d);
        check({31'h0, exp}, {31'h0, d[pos]});
    endtask : checkBit
    task automatic testReset();
        checkReg(ADDR_COUNTER_VALUE, 32'h0);
        checkReg(ADDR_RELOAD_VALUE, {16'h0, RESET_RELOAD});
        checkReg(ADDR_CH1_COMPARE_VALUE, 32'h0);
        checkReg(ADDR_CONTROL_ONE, 32'h0);
        wr(4'h9, 32'hffffffff);
        checkReg(4'h9, 32'h0);
        checkReg(ADDR_EVENT_GEN, 32'h0);
        $display("reset test done");
    endtask : testReset
    task automatic testEncoder();
        logic [2:0] sm [4] = '{SMS_ENC_B, SMS_ENC_A, SMS_ENC_AB, SMS_ENC_AB};
        int c1 [4] = '{2, 2, 4, 6};
        int c2 [4] = '{1, 2, 3, 7};
        int c4 [4] = '{9, 0, 9, 1};
        // set-on-match with compare 2: the output must be raised once all encoder passes are done
        wr(ADDR_CHANNEL_MODE_ONE, 32'h111);
        wr(ADDR_CH1_COMPARE_VALUE, 32'h2);
        wr(ADDR_RELOAD_VALUE, 32'h9);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CONTROL_ONE, 32'h0);
            wr(ADDR_CHANNEL_ENABLE_POLARITY, m == 3 ? 32'h2 : 32'h0);
            wr(ADDR_SLAVE_CONTROL, 32'(sm[m]));
            wr(ADDR_EVENT_GEN, 32'h1);
            wr(ADDR_CONTROL_ONE, 32'h1);
            tmopq_encoder_model_i.turn(4, 1'b0, 6 + 2 * m);
            checkReg(ADDR_COUNTER_VALUE, 32'(c1[m]));
            checkBit(CR1_DIR_POS, m == 3);
            tmopq_encoder_model_i.turn(1, 1'b1, 6);
            checkReg(ADDR_COUNTER_VALUE, 32'(c2[m]));
            checkBit(CR1_DIR_POS, m != 3);
            tmopq_encoder_model_i.turn(3, 1'b1, 6);
            checkReg(ADDR_COUNTER_VALUE, 32'h0);
            tmopq_encoder_model_i.turn(1, 1'b1, 6);
            checkReg(ADDR_COUNTER_VALUE, 32'(c4[m]));
            tmopq_encoder_model_i.turn(1, 1'b0, 6);
        end
        check(32'h1, {31'h0, compareReferenceOut});
        wr(ADDR_CONTROL_ONE, 32'h0);
        wr(ADDR_CHANNEL_ENABLE_POLARITY, 32'h0);
        $display("encoder test done");
    endtask : testEncoder
    task automatic onePulse(input logic [15:0] cmp, input logic [2:0] ocm, input logic fast,
        output int dly, output int wid);
        wr(ADDR_CONTROL_ONE, 32'h0);
        wr(ADDR_RELOAD_VALUE, 32'h1e);
        wr(ADDR_CH1_COMPARE_VALUE, {16'h0, cmp});
        wr(ADDR_CHANNEL_MODE_ONE, 32'h100 | (32'(ocm) << 4) | (32'(fast) << 2));
        wr(ADDR_SLAVE_CONTROL, 32'h66);
        wr(ADDR_EVENT_GEN, 32'h1);
        wr(ADDR_CONTROL_ONE, 32'h8);
        dly = 0;
        wid = 0;
        tmopq_encoder_model_i.drive(1'b1);
        while (compareReferenceOut !== 1'b1 && dly < 200) begin
            @(posedge mclk);
            #1 dly++;
        end
        if (ocm == OCM_PWM2) begin
            while (compareReferenceOut === 1'b1 && wid < 200) begin
                @(posedge mclk);
                #1 wid++;
            end
            repeat (4) @(posedge mclk);
            checkReg(ADDR_COUNTER_VALUE, 32'h0);
            checkBit(CR1_CEN_POS, 1'b0);
        end
        tmopq_encoder_model_i.drive(1'b0);
    endtask : onePulse
    task automatic testPulse();
        int d1, w1, d2, w2;
        onePulse(16'h3, OCM_PWM2, 1'b0, d1, w1);
        check(32'h1b, 32'(w1));
        onePulse(16'h14, OCM_PWM2, 1'b0, d2, w2);
        check(32'ha, 32'(w2));
        check(32'h11, 32'(d2 - d1));
        onePulse(16'h14, OCM_PWM2, 1'b1, d1, w1);
        check(32'h1, 32'(d1 < 8));
        onePulse(16'h14, OCM_SET, 1'b1, d1, w1);
        check(32'h0, 32'(d1 < 8));
        wr(ADDR_CHANNEL_MODE_ONE, 32'(OCM_FORCE_LO) << CM_OCM_LSB);
        $display("pulse test done");
    endtask : testPulse
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        testReset();
        testEncoder();
        testPulse();
        endOfTest();
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            endOfTest();
        end
    end
endmodule : testbench
bind tmopq_timer tmopq_timer_properties tmopq_timer_properties_i (.mclk(mclk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .encoderInA(encoderInA), .encoderInB(encoderInB),
    .compareReferenceOut(compareReferenceOut), .ch1ComparePin(ch1ComparePin));
